// >>> iew_pkg.sv
// constants and types shared by the interrupt enable and idle wake block
package iew_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_IRQ_MASK = 8'h00;
  localparam logic [7:0] OFS_T2_CTRL = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MODE_CMD = 8'h0C;

  // ---------------------------------------------------------------
  // interrupt_enable_mask layout
  // ---------------------------------------------------------------
  localparam int NUM_SRC = 6;
  localparam int GATE_BIT = 7;
  localparam int RSVD_BIT = 6;
  localparam int T2_ON_BIT = 5;
  localparam int SER_ON_BIT = 4;
  localparam int T1_ON_BIT = 3;
  localparam int P1_ON_BIT = 2;
  localparam int T0_ON_BIT = 1;
  localparam int P0_ON_BIT = 0;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] MASK_WRITABLE = 8'hBF;

  // ---------------------------------------------------------------
  // timer_two_control_reg layout
  // ---------------------------------------------------------------
  localparam int T2_OVF_BIT = 0;
  localparam int T2_PIN_BIT = 1;
  localparam int T2_UPDN_BIT = 2;
  localparam int T2_BAUD_BIT = 3;

  // ---------------------------------------------------------------
  // status and command layout
  // ---------------------------------------------------------------
  localparam int ST_VEC_LSB = 6;
  localparam int ST_REQ_BIT = 9;
  localparam int ST_IDLE_BIT = 10;
  localparam int ST_WIN_BIT = 11;
  localparam int CMD_IDLE_BIT = 0;

  // ---------------------------------------------------------------
  // machine cycle timing
  // ---------------------------------------------------------------
  localparam logic [2:0] NUM_STATES = 3'h6;
  localparam logic [2:0] POLL_STATE = 3'h4;
  localparam logic [2:0] T2_SET_STATE = 3'h1;
  localparam logic [1:0] EXIT_CYCLES = 2'h2;

  // ---------------------------------------------------------------
  // synchroniser: bit0 pin zero (low active), bit1 pin one, bit2 reset pin
  // ---------------------------------------------------------------
  localparam int SYNC_W = 3;
  localparam logic [2:0] SYNC_RESET = 3'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // vector index equals enable bit position; lower index wins
  typedef enum logic [2:0] {
    VEC_PIN0,
    VEC_T0,
    VEC_PIN1,
    VEC_T1,
    VEC_SER,
    VEC_T2
  } iew_vec_t;

  typedef enum logic [1:0] {
    MD_RUN,
    MD_IDLE,
    MD_EXIT,
    MD_RESET
  } iew_mode_t;

endpackage : iew_pkg

// >>> iew_sync.sv
// two-flop synchroniser for the asynchronous pin inputs
`timescale 1ns/1ns
module iew_sync
  import iew_pkg::*;
(
  input wire logic sys_clk_i, // system clock
  input wire logic rst_n_i, // async reset, low active
  input wire logic ce_i, // clock enable
  input wire logic [SYNC_W-1:0] async_i, // raw pin levels
  output logic [SYNC_W-1:0] sync_o // synchronised levels
);

  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] safe;
  } iew_sync_t;

  iew_sync_t st;
  iew_sync_t next_st;

  // meta is read by safe only
  always_comb begin
    next_st = st;
    next_st.meta = async_i;
    next_st.safe = st.meta;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= {SYNC_RESET, SYNC_RESET};
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign sync_o = st.safe;

endmodule : iew_sync

// >>> iew_timing.sv
// divide-by-two phase stage and machine cycle state counter
`timescale 1ns/1ns
module iew_timing
  import iew_pkg::*;
(
  input wire logic sys_clk_i, // oscillator clock
  input wire logic rst_n_i, // async reset, low active
  input wire logic ce_i, // clock enable
  output logic state_two_phase_two_o, // state two phase two strobe
  output logic state_five_phase_two_o, // state five phase two strobe
  output logic cycle_end_o // last phase of a machine cycle
);

  typedef struct packed {
    logic half;
    logic [2:0] state;
  } iew_tim_t;

  iew_tim_t st;
  iew_tim_t next_st;

  // the toggle stage makes every phase one full oscillator period
  always_comb begin
    next_st = st;
    next_st.half = ~st.half;
    if (st.half) begin
      if (st.state == NUM_STATES - 3'h1) begin
        next_st.state = 3'h0;
      end else begin
        next_st.state = st.state + 3'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign state_two_phase_two_o = ce_i & st.half & (st.state == T2_SET_STATE);
  assign state_five_phase_two_o = ce_i & st.half & (st.state == POLL_STATE);
  assign cycle_end_o = ce_i & st.half & (st.state == NUM_STATES - 3'h1);

  property p_half_toggle;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    ce_i |=> (st.half != $past(st.half));
  endproperty
  a_half_toggle: assert property (p_half_toggle)
    else $error("phase stage did not toggle");

endmodule : iew_timing

// >>> iew_top.sv
// interrupt enable, request polling and idle wake logic with an AXI4-Lite slave
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
module iew_top
  import iew_pkg::*;
(
  input wire logic sys_clk_i, // 50 MHz oscillator clock
  input wire logic rst_n_i, // async reset, low active
  input wire logic ce_i, // clock enable, freezes all state when low
  input wire logic ext_request_pin_zero_n_i, // external request pin zero, low active
  input wire logic ext_request_pin_one_n_i, // external request pin one, low active
  input wire logic hw_reset_pin_i, // hardware reset pin, high active
  input wire logic timer_zero_ovf_i, // timer zero overflow pulse
  input wire logic timer_one_ovf_i, // timer one overflow pulse
  input wire logic timer_two_ovf_i, // timer two overflow or underflow pulse
  input wire logic timer_two_pin_evt_i, // timer two trigger pin event pulse
  input wire logic serial_req_i, // serial port request level
  input wire logic cpu_ack_i, // vectoring acknowledge pulse
  input wire logic [7:0] s_axi_awaddr_i, // write address
  input wire logic s_axi_awvalid_i, // write address valid
  output logic s_axi_awready_o, // write address ready
  input wire logic [31:0] s_axi_wdata_i, // write data
  input wire logic [3:0] s_axi_wstrb_i, // write byte strobes
  input wire logic s_axi_wvalid_i, // write data valid
  output logic s_axi_wready_o, // write data ready
  output logic [1:0] s_axi_bresp_o, // write response
  output logic s_axi_bvalid_o, // write response valid
  input wire logic s_axi_bready_i, // write response ready
  input wire logic [7:0] s_axi_araddr_i, // read address
  input wire logic s_axi_arvalid_i, // read address valid
  output logic s_axi_arready_o, // read address ready
  output logic [31:0] s_axi_rdata_o, // read data
  output logic [1:0] s_axi_rresp_o, // read response
  output logic s_axi_rvalid_o, // read data valid
  input wire logic s_axi_rready_i, // read data ready
  output logic irq_req_o, // request toward the vectoring logic
  output logic [2:0] irq_vec_o, // selected vector index
  output logic idle_o, // idle mode active
  output logic cpu_run_o, // CPU may execute
  output logic ram_access_ok_o, // internal RAM access allowed
  output logic port_write_ok_o, // port pin writes allowed
  output logic internal_reset_o // internal reset sequence active
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] interrupt_enable_mask;
    logic timer_zero_overflow_flag;
    logic timer_one_overflow_flag;
    logic timer_two_overflow_flag;
    logic timer_two_pin_flag;
    logic t2_updown;
    logic t2_baud;
    logic ev_t0;
    logic ev_t1;
    logic ev_t2;
    logic ev_t2pin;
    logic req;
    iew_vec_t vec;
    iew_mode_t mode;
    logic [1:0] exit_cnt;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic aw_rdy;
    logic w_rdy;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic cpu_run;
    logic ram_ok;
    logic port_ok;
    logic idle;
    logic in_rst;
  } iew_state_t;

  iew_state_t st;
  iew_state_t next_st;

  logic [SYNC_W-1:0] pin_sync;
  logic state_two_phase_two;
  logic state_five_phase_two;
  logic cycle_end;
  logic [NUM_SRC-1:0] src;
  logic [NUM_SRC-1:0] enabled;
  iew_vec_t prio_sel;
  logic t2_clear_wr;
  logic rst_pin;

  // ---------------------------------------------------------------
  // pin synchroniser and machine cycle timing
  // ---------------------------------------------------------------
  iew_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .async_i({hw_reset_pin_i, ext_request_pin_one_n_i, ext_request_pin_zero_n_i}),
    .sync_o(pin_sync)
  );

  iew_timing u_timing (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .state_two_phase_two_o(state_two_phase_two),
    .state_five_phase_two_o(state_five_phase_two),
    .cycle_end_o(cycle_end)
  );

  assign rst_pin = pin_sync[2];

  // ---------------------------------------------------------------
  // request sources and priority
  // ---------------------------------------------------------------
  // pins are level sensitive: a low pin requests while it stays low
  always_comb begin
    src[VEC_PIN0] = ~pin_sync[0];
    src[VEC_T0] = st.timer_zero_overflow_flag;
    src[VEC_PIN1] = ~pin_sync[1];
    src[VEC_T1] = st.timer_one_overflow_flag;
    src[VEC_SER] = serial_req_i;
    // in up/down mode the pin flag is a 17th count bit, not a request
    src[VEC_T2] = st.timer_two_overflow_flag | (st.timer_two_pin_flag & ~st.t2_updown);
    enabled = src & st.interrupt_enable_mask[NUM_SRC-1:0]
      & {NUM_SRC{st.interrupt_enable_mask[GATE_BIT]}};
    prio_sel = VEC_PIN0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (enabled[i]) begin
        prio_sel = iew_vec_t'(i[2:0]);
      end
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    t2_clear_wr = 1'b0;

    // bus write channels, taken in either order
    if (st.aw_rdy && s_axi_awvalid_i) begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = s_axi_awaddr_i;
    end
    if (st.w_rdy && s_axi_wvalid_i) begin
      next_st.w_got = 1'b1;
      next_st.w_data = s_axi_wdata_i;
      next_st.w_strb = s_axi_wstrb_i;
    end
    if (st.bvalid && s_axi_bready_i) begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_got && st.w_got && !st.bvalid) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      // registers are frozen outside run mode; the write still completes
      case (st.aw_addr[7:2])
        OFS_IRQ_MASK[7:2]: begin
          if (st.w_strb[0] && st.mode == MD_RUN) begin
            next_st.interrupt_enable_mask = st.w_data[7:0] & MASK_WRITABLE;
          end
        end
        OFS_T2_CTRL[7:2]: begin
          if (st.w_strb[0] && st.mode == MD_RUN) begin
            // flags clear by writing one here, and the pin flag also by toggling in up/down mode; never by vectoring
            t2_clear_wr = st.w_data[T2_OVF_BIT] | st.w_data[T2_PIN_BIT];
            if (st.w_data[T2_OVF_BIT]) begin
              next_st.timer_two_overflow_flag = 1'b0;
            end
            if (st.w_data[T2_PIN_BIT]) begin
              next_st.timer_two_pin_flag = 1'b0;
            end
            next_st.t2_updown = st.w_data[T2_UPDN_BIT];
            next_st.t2_baud = st.w_data[T2_BAUD_BIT];
          end
        end
        OFS_STATUS[7:2]: begin
          next_st.bresp = RESP_OKAY;
        end
        OFS_MODE_CMD[7:2]: begin
          if (st.w_strb[0] && st.w_data[CMD_IDLE_BIT] && st.mode == MD_RUN) begin
            next_st.mode = MD_IDLE;
          end
        end
        default: begin
          next_st.bresp = RESP_DECERR;
        end
      endcase
    end

    // read channel
    if (st.rvalid && s_axi_rready_i) begin
      next_st.rvalid = 1'b0;
    end
    if (st.ar_rdy && s_axi_arvalid_i) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      next_st.rdata = 32'h00000000;
      case (s_axi_araddr_i[7:2])
        OFS_IRQ_MASK[7:2]: begin
          next_st.rdata[7:0] = st.interrupt_enable_mask;
        end
        OFS_T2_CTRL[7:2]: begin
          next_st.rdata[T2_OVF_BIT] = st.timer_two_overflow_flag;
          next_st.rdata[T2_PIN_BIT] = st.timer_two_pin_flag;
          next_st.rdata[T2_UPDN_BIT] = st.t2_updown;
          next_st.rdata[T2_BAUD_BIT] = st.t2_baud;
        end
        OFS_STATUS[7:2]: begin
          next_st.rdata[NUM_SRC-1:0] = src;
          next_st.rdata[ST_VEC_LSB+2:ST_VEC_LSB] = st.vec;
          next_st.rdata[ST_REQ_BIT] = st.req;
          next_st.rdata[ST_IDLE_BIT] = (st.mode == MD_IDLE);
          next_st.rdata[ST_WIN_BIT] = (st.mode == MD_EXIT);
        end
        OFS_MODE_CMD[7:2]: begin
          next_st.rdata[CMD_IDLE_BIT] = (st.mode == MD_IDLE);
        end
        default: begin
          next_st.rresp = RESP_DECERR;
        end
      endcase
    end

    // vectoring clears only the timer zero and one flags
    if (cpu_ack_i && st.req) begin
      next_st.req = 1'b0;
      if (st.vec == VEC_T0) begin
        next_st.timer_zero_overflow_flag = 1'b0;
      end
      if (st.vec == VEC_T1) begin
        next_st.timer_one_overflow_flag = 1'b0;
      end
    end

    // timer events wait for their setting phase; later sets beat clears
    next_st.ev_t0 = st.ev_t0 | timer_zero_ovf_i;
    next_st.ev_t1 = st.ev_t1 | timer_one_ovf_i;
    next_st.ev_t2 = st.ev_t2 | timer_two_ovf_i;
    next_st.ev_t2pin = st.ev_t2pin | timer_two_pin_evt_i;
    if (state_five_phase_two) begin
      // polling reads st, so a flag set now is seen one cycle later
      if (st.ev_t0) begin
        next_st.timer_zero_overflow_flag = 1'b1;
      end
      if (st.ev_t1) begin
        next_st.timer_one_overflow_flag = 1'b1;
      end
      next_st.ev_t0 = timer_zero_ovf_i;
      next_st.ev_t1 = timer_one_ovf_i;
    end
    if (state_two_phase_two) begin
      // set ahead of the poll, so it is served in the same cycle
      if (st.ev_t2 && !st.t2_baud) begin
        next_st.timer_two_overflow_flag = 1'b1;
      end
      if (st.ev_t2 && st.t2_updown) begin
        next_st.timer_two_pin_flag = ~st.timer_two_pin_flag;
      end
      if (st.ev_t2pin && !st.t2_updown) begin
        next_st.timer_two_pin_flag = 1'b1;
      end
      next_st.ev_t2 = timer_two_ovf_i;
      next_st.ev_t2pin = timer_two_pin_evt_i;
    end

    // polling keeps running in idle
    if (state_five_phase_two && |enabled) begin
      if (!st.req) begin
        next_st.req = 1'b1;
        next_st.vec = prio_sel;
      end
      if (st.mode == MD_IDLE && next_st.mode == MD_IDLE) begin
        next_st.mode = MD_RUN;
      end
    end

    // mode sequencing for the hardware reset pin
    case (st.mode)
      MD_RUN: begin
        if (rst_pin) begin
          next_st.mode = MD_RESET;
        end
      end
      MD_IDLE: begin
        if (rst_pin) begin
          next_st.mode = MD_EXIT;
          next_st.exit_cnt = 2'h0;
        end
      end
      MD_EXIT: begin
        // CPU runs briefly before the internal reset takes over
        if (cycle_end) begin
          next_st.exit_cnt = st.exit_cnt + 2'h1;
          if (st.exit_cnt == EXIT_CYCLES - 2'h1) begin
            next_st.mode = MD_RESET;
          end
        end
      end
      MD_RESET: begin
        next_st.interrupt_enable_mask = MASK_RESET;
        next_st.t2_updown = 1'b0;
        next_st.t2_baud = 1'b0;
        next_st.req = 1'b0;
        if (!rst_pin) begin
          next_st.mode = MD_RUN;
        end
      end
      default: begin
        next_st.mode = MD_RESET;
      end
    endcase

    // registered handshake and control outputs
    next_st.aw_rdy = !next_st.aw_got && !next_st.bvalid;
    next_st.w_rdy = !next_st.w_got && !next_st.bvalid;
    next_st.ar_rdy = !next_st.rvalid;
    next_st.cpu_run = (next_st.mode == MD_RUN) || (next_st.mode == MD_EXIT);
    next_st.ram_ok = (next_st.mode == MD_RUN);
    next_st.port_ok = (next_st.mode != MD_RESET);
    next_st.idle = (next_st.mode == MD_IDLE);
    next_st.in_rst = (next_st.mode == MD_RESET);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
      st.aw_rdy <= 1'b1;
      st.w_rdy <= 1'b1;
      st.ar_rdy <= 1'b1;
      st.cpu_run <= 1'b1;
      st.ram_ok <= 1'b1;
      st.port_ok <= 1'b1;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign s_axi_awready_o = st.aw_rdy;
  assign s_axi_wready_o = st.w_rdy;
  assign s_axi_bresp_o = st.bresp;
  assign s_axi_bvalid_o = st.bvalid;
  assign s_axi_arready_o = st.ar_rdy;
  assign s_axi_rdata_o = st.rdata;
  assign s_axi_rresp_o = st.rresp;
  assign s_axi_rvalid_o = st.rvalid;
  assign irq_req_o = st.req;
  assign irq_vec_o = st.vec;
  assign idle_o = st.idle;
  assign cpu_run_o = st.cpu_run;
  assign ram_access_ok_o = st.ram_ok;
  assign port_write_ok_o = st.port_ok;
  assign internal_reset_o = st.in_rst;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_gate_blocks;
    (state_five_phase_two && !st.interrupt_enable_mask[GATE_BIT] && !st.req) |=> !st.req;
  endproperty
  a_gate_blocks: assert property (p_gate_blocks)
    else $error("request raised with global gate off");

  property p_enable_needed;
    $rose(st.req) |-> $past(enabled[prio_sel]) && $past(state_five_phase_two);
  endproperty
  a_enable_needed: assert property (p_enable_needed)
    else $error("request raised without an enabled source");

  property p_rsvd_zero;
    st.interrupt_enable_mask[RSVD_BIT] == 1'b0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved enable bit set");

  property p_priority;
    $rose(st.req) |-> st.vec == $past(prio_sel);
  endproperty
  a_priority: assert property (p_priority)
    else $error("wrong vector chosen");

  property p_t2_flag_kept;
    (st.timer_two_overflow_flag && !t2_clear_wr && st.mode != MD_RESET && ce_i)
      |=> st.timer_two_overflow_flag;
  endproperty
  a_t2_flag_kept: assert property (p_t2_flag_kept)
    else $error("timer two flag cleared by hardware");

  property p_t0_set;
    (state_five_phase_two && st.ev_t0) |=> st.timer_zero_overflow_flag;
  endproperty
  a_t0_set: assert property (p_t0_set)
    else $error("timer zero flag not set at its phase");

  property p_t2_set;
    (state_two_phase_two && st.ev_t2 && !st.t2_baud) |=> st.timer_two_overflow_flag;
  endproperty
  a_t2_set: assert property (p_t2_set)
    else $error("timer two flag not set at its phase");

  property p_baud_no_flag;
    (st.t2_baud && !st.timer_two_overflow_flag) |=> !st.timer_two_overflow_flag;
  endproperty
  a_baud_no_flag: assert property (p_baud_no_flag)
    else $error("rollover set flag in baud mode");

  property p_idle_wake;
    (st.mode == MD_IDLE && state_five_phase_two && |enabled && !rst_pin) |=> st.mode == MD_RUN;
  endproperty
  a_idle_wake: assert property (p_idle_wake)
    else $error("enabled request did not end idle");

  property p_exit_window;
    (st.mode == MD_EXIT && cycle_end && st.exit_cnt == 2'h1)
      |=> (st.mode == MD_RESET) && !ram_access_ok_o && !port_write_ok_o;
  endproperty
  a_exit_window: assert property (p_exit_window)
    else $error("reset exit window wrong length");

endmodule : iew_top

// >>> iew_cpu_model.sv
// vectoring side model: acknowledges a pending request after a set wait
`timescale 1ns/1ns
module iew_cpu_model (
  input wire logic sys_clk_i, // clock
  input wire logic rst_n_i, // reset, low active
  input wire logic irq_req_i, // pending request
  input wire logic [3:0] dly_i, // cycles to wait before acking
  output logic cpu_ack_o // one-cycle acknowledge
);
  logic [3:0] cnt;
  // one pulse per request; the req drops on the edge that samples it
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 4'h0;
      cpu_ack_o <= 1'b0;
    end else begin
      cpu_ack_o <= irq_req_i && !cpu_ack_o && cnt == dly_i;
      cnt <= (irq_req_i && !cpu_ack_o && cnt != dly_i) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule : iew_cpu_model

// >>> iew_top_tb.sv
// self-checking bench for the interrupt enable and idle wake block
`timescale 1ns/1ns
module iew_top_tb;
  import iew_pkg::*;
  logic clk = 0, rst_n = 0, hw = 0, awv = 0, wv = 0, arv = 0, pe = 0;
  logic [5:0] src = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdata, d;
  logic [3:0] dly = 0, mon;
  logic [2:0] vec;
  logic [1:0] bresp, rresp, r;
  logic awr, wrdy, bv, arr, rv, irq, idle, run, ram_ok, port_ok, irst, ack;
  int err_total = 0, cmp_count = 0;
  assign mon = {run, irst, idle, irq};
  always #10 clk = ~clk;
  iew_top dut_u (.sys_clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1), .hw_reset_pin_i(hw),
    .ext_request_pin_zero_n_i(~src[0]), .ext_request_pin_one_n_i(~src[2]),
    .timer_zero_ovf_i(src[1]), .timer_one_ovf_i(src[3]), .timer_two_ovf_i(src[5]),
    .timer_two_pin_evt_i(pe), .serial_req_i(src[4]), .cpu_ack_i(ack),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(1'b1),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(1'b1),
    .irq_req_o(irq), .irq_vec_o(vec), .idle_o(idle), .cpu_run_o(run),
    .ram_access_ok_o(ram_ok), .port_write_ok_o(port_ok), .internal_reset_o(irst));
  iew_cpu_model cpu_u (.sys_clk_i(clk), .rst_n_i(rst_n), .irq_req_i(irq), .dly_i(dly),
    .cpu_ack_o(ack));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic lim(input logic hit);
    if (hit) begin
      $display("Error wait expected done seen timeout");
      err_total++;
      conclude();
    end
  endtask : lim
  // bounded wait for one monitored output to reach a level
  task automatic w(input int s, input logic lv);
    int n = 0;
    cmp_count++;
    while (n < 400 && mon[s] !== lv) begin
      @(posedge clk);
      n++;
    end
    lim(mon[s] !== lv);
  endtask : w
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n = 0;
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (bv !== 1'b1 && n < 50);
    r = bresp;
    lim(bv !== 1'b1);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n = 0;
    ara <= a;
    arv <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1 && n < 50);
    d = rdata;
    r = rresp;
    lim(rv !== 1'b1);
  endtask : rd
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(OFS_IRQ_MASK);
    chk("mask_reset", d, 32'h0);
    chk("rresp_ok", 32'(r), 32'h0);
    // software keeps the reserved enable bit at zero
    wr(OFS_IRQ_MASK, 32'hBF);
    chk("bresp_ok", 32'(r), 32'h0);
    rd(OFS_IRQ_MASK);
    chk("mask_rw", d, 32'hBF);
    rd(8'h10);
    chk("unmapped", 32'(r), 32'h3);
    wr(8'h10, 32'h0);
    chk("unmapped_wr", 32'(r), 32'h3);
    // each source against a pending timer two request, gate closed first
    for (int i = 0; i < NUM_SRC; i++) begin
      dly <= i[0] ? 4'hC : 4'h0;
      wr(OFS_IRQ_MASK, 32'h20 | (32'h1 << i));
      src <= 6'h20 | (6'h1 << i);
      @(posedge clk);
      src <= (6'h1 << i) & 6'h15;
      repeat (30) @(posedge clk);
      chk("gate_off", 32'(irq), 32'h0);
      wr(OFS_IRQ_MASK, 32'hA0 | (32'h1 << i));
      w(0, 1'b1);
      chk("vec_first", 32'(vec), 32'(i));
      src <= 6'h0;
      w(0, 1'b0);
      w(0, 1'b1);
      chk("vec_t2", 32'(vec), 32'h5);
      wr(OFS_T2_CTRL, 32'h3);
      repeat (40) @(posedge clk);
    end
    // timer two modes: baud rollover, up/down wrap, trigger pin event
    wr(OFS_IRQ_MASK, 32'h80);
    wr(OFS_T2_CTRL, 32'h8);
    src <= 6'h20;
    @(posedge clk);
    src <= 6'h0;
    repeat (30) @(posedge clk);
    rd(OFS_T2_CTRL);
    chk("baud_flag", d, 32'h8);
    wr(OFS_T2_CTRL, 32'h4);
    src <= 6'h20;
    @(posedge clk);
    src <= 6'h0;
    repeat (30) @(posedge clk);
    rd(OFS_T2_CTRL);
    chk("updn_flags", d, 32'h7);
    wr(OFS_T2_CTRL, 32'h5);
    wr(OFS_IRQ_MASK, 32'hA0);
    repeat (30) @(posedge clk);
    chk("updn_no_irq", 32'(irq), 32'h0);
    wr(OFS_T2_CTRL, 32'h2);
    pe <= 1'b1;
    @(posedge clk);
    pe <= 1'b0;
    w(0, 1'b1);
    chk("pin_vec", 32'(vec), 32'h5);
    rd(OFS_T2_CTRL);
    chk("pin_flag", d, 32'h2);
    wr(OFS_T2_CTRL, 32'h2);
    repeat (40) @(posedge clk);
    wr(OFS_IRQ_MASK, 32'h82);
    // no port write follows the idle entry
    wr(OFS_MODE_CMD, 32'h1);
    chk("idle_on", 32'(idle), 32'h1);
    rd(OFS_STATUS);
    chk("status_idle", d, 32'h540);
    wr(OFS_IRQ_MASK, 32'h0);
    rd(OFS_IRQ_MASK);
    chk("idle_keep", d, 32'h82);
    src <= 6'h2;
    @(posedge clk);
    src <= 6'h0;
    w(1, 1'b0);
    repeat (30) @(posedge clk);
    wr(OFS_MODE_CMD, 32'h1);
    hw <= 1'b1;
    w(3, 1'b1);
    chk("exit_window", 32'({run, ram_ok, port_ok}), 32'h5);
    w(2, 1'b1);
    chk("in_reset", 32'({run, port_ok}), 32'h0);
    hw <= 1'b0;
    w(2, 1'b0);
    rd(OFS_IRQ_MASK);
    chk("mask_cleared", d, 32'h0);
    // reset pin straight from run mode skips the exit window
    hw <= 1'b1;
    w(2, 1'b1);
    chk("run_reset", 32'({run, port_ok, ram_ok}), 32'h0);
    hw <= 1'b0;
    w(2, 1'b0);
    conclude();
  end
endmodule : iew_top_tb
